// ---- shared/port_mode_defs.svh ----
`ifndef PORT_MODE_DEFS_SVH
`define PORT_MODE_DEFS_SVH

// Byte addresses of the configuration I/O space, one word per register
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_DIR_A 8'h10
`define OFF_DIR_B 8'h14
`define OFF_DIR_C 8'h18
`define OFF_DIR_D 8'h1C
`define OFF_DOUT_A 8'h20
`define OFF_DOUT_B 8'h24
`define OFF_DOUT_C 8'h28
`define OFF_DOUT_D 8'h2C
`define OFF_DIN_A 8'h30
`define OFF_DIN_B 8'h34
`define OFF_DIN_C 8'h38
`define OFF_DIN_D 8'h3C
`define OFF_OE_A 8'h40
`define OFF_OE_B 8'h44
`define OFF_OE_C 8'h48
`define OFF_OE_D 8'h4C
`define OFF_MEM_MAP 8'h50

// Field positions and reset values
`define PERIPH_BIT 7
`define CFG_RESET 8'h00
`define PORT_D_RESET 3'h0

`endif

// ---- shared/port_mode_pkg.sv ----
`default_nettype none

package port_mode_pkg;

  // Host bus variants that change the latched address layout
  typedef enum logic [1:0] {
    BUS_MUX8 = 2'h0,
    BUS_NONMUX8 = 2'h1,
    BUS_BURST8 = 2'h3,
    BUS_PAGE = 2'h2
  } host_bus_e;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  // One bit per pin of the four ports
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [2:0] d;
  } port_pins_s;

endpackage

`default_nettype wire

// ---- core/port_mode_select.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "port_mode_defs.svh"

module port_mode_select
  import port_mode_pkg::*;
#(
  parameter host_bus_e HOST_BUS = BUS_MUX8,
  parameter logic PORT_B_HIGH = 1'b0,
  parameter logic DATA_PORT_A = 1'b0,
  parameter logic PERIPH_DEFINED = 1'b0,
  parameter port_pins_s ARRAY_OUT_MASK = '0,
  parameter port_pins_s ADDR_IN_MASK = '0,
  parameter logic SCAN_CFG_EN = 1'b0,
  parameter logic [7:0] SCAN_PIN_MASK = 8'h0F,
  parameter logic [7:0] SCAN_TDO_MASK = 8'h08
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wb_req_s wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire port_pins_s pin_in_i,
  output port_pins_s pin_out_o,
  output port_pins_s pin_oe_o,
  input wire port_pins_s array_out_i,
  input wire port_pins_s array_oe_i,
  output port_pins_s array_in_o,
  output port_pins_s input_latch_cell_o,
  input wire logic [15:0] addr_i,
  input wire logic address_strobe_i,
  input wire logic [7:0] host_data_i,
  input wire logic data_drive_i,
  output logic [7:0] host_data_o,
  input wire logic periph_select_a_i,
  input wire logic periph_select_b_i,
  input wire logic scan_port_select_i,
  input wire logic scan_enable_i,
  input wire logic scan_tdo_i,
  output logic scan_active_o
);

  // Configuration and data registers
  logic [7:0] ctrl_a_ff, ctrl_b_ff;
  logic [7:0] dir_a_ff, dir_b_ff, dir_c_ff;
  logic [2:0] dir_d_ff;
  logic [7:0] dout_a_ff, dout_b_ff, dout_c_ff;
  logic [2:0] dout_d_ff;
  logic periph_ff;
  // Output flops
  logic ack_ff;
  logic [31:0] dat_ff;
  port_pins_s pin_out_ff, pin_oe_ff, array_in_ff, latch_ff;
  logic [7:0] host_data_ff;
  logic scan_ff;

  // Latched address bits for a port: {valid mask, data}
  function automatic logic [15:0] addr_map(input logic is_b, input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    case (HOST_BUS)
      BUS_MUX8: begin
        r = (is_b && PORT_B_HIGH) ? {8'hFF, a[15:8]} : {8'hFF, a[7:0]};
      end
      BUS_NONMUX8: begin
        r = is_b ? {8'hFF, a[7:0]} : 16'h0000;
      end
      BUS_PAGE: begin
        r = is_b ? {8'hFF, a[15:8]} : 16'h0000;
      end
      BUS_BURST8: begin
        r = is_b ? {8'h0F, 4'h0, a[11:8]} : {8'hF0, a[7:4], 4'h0};
      end
      default: begin
        r = 16'h0000;
      end
    endcase
    return r;
  endfunction

  // Per-pin mux for general pins: {output enable, output value}
  function automatic logic [15:0] pin_mux(input logic [7:0] ctrl, input logic [7:0] dir,
                                           input logic [7:0] dout, input logic [15:0] amap,
                                           input logic [7:0] amask, input logic [7:0] aout,
                                           input logic [7:0] aoe);
    logic [7:0] oe, asel, out;
    oe = dir | aoe;
    asel = ctrl & amap[15:8];
    out = (asel & amap[7:0]) | (~asel & amask & aout) | (~asel & ~amask & dout);
    return {oe, out};
  endfunction

  // Register read decode, narrow data in the low byte
  function automatic logic [7:0] rd_byte(input logic [7:0] adr);
    logic [7:0] r;
    case (adr)
      `OFF_CTRL_A: r = ctrl_a_ff;
      `OFF_CTRL_B: r = ctrl_b_ff;
      `OFF_DIR_A: r = dir_a_ff;
      `OFF_DIR_B: r = dir_b_ff;
      `OFF_DIR_C: r = dir_c_ff;
      `OFF_DIR_D: r = {5'h00, dir_d_ff};
      `OFF_DOUT_A: r = dout_a_ff;
      `OFF_DOUT_B: r = dout_b_ff;
      `OFF_DOUT_C: r = dout_c_ff;
      `OFF_DOUT_D: r = {5'h00, dout_d_ff};
      `OFF_DIN_A: r = pin_in_i.a;
      `OFF_DIN_B: r = pin_in_i.b;
      `OFF_DIN_C: r = pin_in_i.c;
      `OFF_DIN_D: r = {5'h00, pin_in_i.d};
      `OFF_OE_A: r = pin_oe_ff.a;
      `OFF_OE_B: r = pin_oe_ff.b;
      `OFF_OE_C: r = pin_oe_ff.c;
      `OFF_OE_D: r = {5'h00, pin_oe_ff.d};
      `OFF_MEM_MAP: r = {periph_ff, 7'h00};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Bus decode; unmapped addresses still answer, reading zero
  wire req = wb_i.cyc && wb_i.stb;
  wire wr_en = req && wb_i.we && ack_ff && wb_i.sel[0];
  wire [7:0] wb_byte = wb_i.dat[7:0];
  logic [31:0] rd_word;

  // Process form so a register or pin change alone refreshes the read word
  always_comb begin
    rd_word = {24'h000000, rd_byte(wb_i.adr)};
  end

  // Run-time mode conditions; configuration-time ones come from parameters
  wire periph_on = PERIPH_DEFINED && periph_ff && !DATA_PORT_A;
  wire periph_sel = periph_select_a_i || periph_select_b_i;
  wire scan_on = SCAN_CFG_EN || scan_enable_i || scan_port_select_i;

  // General pin muxes; ports C and D have no control register
  wire [15:0] amap_a = addr_map(1'b0, addr_i);
  wire [15:0] amap_b = addr_map(1'b1, addr_i);
  wire [15:0] mux_a = pin_mux(ctrl_a_ff, dir_a_ff, dout_a_ff, amap_a, ARRAY_OUT_MASK.a,
                              array_out_i.a, array_oe_i.a);
  wire [15:0] mux_b = pin_mux(ctrl_b_ff, dir_b_ff, dout_b_ff, amap_b, ARRAY_OUT_MASK.b,
                              array_out_i.b, array_oe_i.b);
  wire [15:0] mux_c = pin_mux(8'h00, dir_c_ff, dout_c_ff, 16'h0000, ARRAY_OUT_MASK.c,
                              array_out_i.c, array_oe_i.c);
  wire [15:0] mux_d = pin_mux(8'h00, {5'h00, dir_d_ff}, {5'h00, dout_d_ff}, 16'h0000,
                              {5'h00, ARRAY_OUT_MASK.d}, {5'h00, array_out_i.d},
                              {5'h00, array_oe_i.d});

  // Port A overrides: data port disables every general function
  wire [7:0] nxt_oe_a = DATA_PORT_A ? {8{data_drive_i}} :
                        periph_on ? {8{periph_sel && data_drive_i}} : mux_a[15:8];
  wire [7:0] nxt_out_a = (DATA_PORT_A || periph_on) ? host_data_i : mux_a[7:0];

  // Port C: scan pins released to the scan logic, test output driven
  wire [7:0] scan_pins = scan_on ? SCAN_PIN_MASK : 8'h00;
  wire [7:0] nxt_oe_c = (mux_c[15:8] & ~scan_pins) | (scan_pins & SCAN_TDO_MASK);
  wire [7:0] nxt_out_c = (mux_c[7:0] & ~scan_pins) | (scan_pins & {8{scan_tdo_i}});

  // Bus handshake: ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req && !ack_ff;
      if (req && !ack_ff) begin
        dat_ff <= rd_word;
      end
    end
  end

  // Writes land on the edge where the master sees ack, not earlier
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_ff <= `CFG_RESET;
      ctrl_b_ff <= `CFG_RESET;
      dir_a_ff <= `CFG_RESET;
      dir_b_ff <= `CFG_RESET;
      dir_c_ff <= `CFG_RESET;
      dir_d_ff <= `PORT_D_RESET;
      dout_a_ff <= `CFG_RESET;
      dout_b_ff <= `CFG_RESET;
      dout_c_ff <= `CFG_RESET;
      dout_d_ff <= `PORT_D_RESET;
      periph_ff <= 1'b0;
    end else if (wr_en) begin
      case (wb_i.adr)
        `OFF_CTRL_A: ctrl_a_ff <= wb_byte;
        `OFF_CTRL_B: ctrl_b_ff <= wb_byte;
        `OFF_DIR_A: dir_a_ff <= wb_byte;
        `OFF_DIR_B: dir_b_ff <= wb_byte;
        `OFF_DIR_C: dir_c_ff <= wb_byte;
        `OFF_DIR_D: dir_d_ff <= wb_byte[2:0];
        `OFF_DOUT_A: dout_a_ff <= wb_byte;
        `OFF_DOUT_B: dout_b_ff <= wb_byte;
        `OFF_DOUT_C: dout_c_ff <= wb_byte;
        `OFF_DOUT_D: dout_d_ff <= wb_byte[2:0];
        `OFF_MEM_MAP: periph_ff <= wb_byte[`PERIPH_BIT];
        default: ;
      endcase
    end
  end

  // Pin drivers registered so outputs come from flops; costs one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      scan_ff <= 1'b0;
    end else begin
      pin_out_ff <= {nxt_out_a, mux_b[7:0], nxt_out_c, mux_d[2:0]};
      pin_oe_ff <= {nxt_oe_a, mux_b[15:8], nxt_oe_c, mux_d[10:8]};
      scan_ff <= scan_on;
    end
  end

  // Pin inputs toward array and host; address inputs caught on the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      array_in_ff <= '0;
      latch_ff <= '0;
      host_data_ff <= 8'h00;
    end else begin
      array_in_ff <= pin_in_i;
      host_data_ff <= pin_in_i.a;
      if (address_strobe_i) begin
        latch_ff <= pin_in_i & ADDR_IN_MASK;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign pin_out_o = pin_out_ff;
  assign pin_oe_o = pin_oe_ff;
  assign array_in_o = array_in_ff;
  assign input_latch_cell_o = latch_ff;
  assign host_data_o = host_data_ff;
  assign scan_active_o = scan_ff;

  // Checks run on the one clock, quiet during reset except the reset-zero check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_start;
    req && !ack_ff;
  endsequence

  sequence s_wr_dir_b;
    req && wb_i.we && wb_i.sel[0] && ack_ff && wb_i.adr == `OFF_DIR_B;
  endsequence

  // Ack comes the cycle after a fresh request and lasts one cycle
  property p_ack_timing;
    s_req_start |=> ack_ff ##1 !ack_ff;
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("ack timing wrong");

  // Written direction byte lands bit for bit
  property p_dir_write;
    s_wr_dir_b |=> dir_b_ff == $past(wb_i.dat[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  // Registers hold zero right after reset
  property p_reset_zero;
    @(posedge clk_i) disable iff (1'b0) $past(rst_i) |->
      (ctrl_a_ff | ctrl_b_ff | dir_a_ff | dir_b_ff | dir_c_ff) == 8'h00 && !periph_ff;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not cleared");

  // Port D enable is direction OR product term
  property p_oe_or;
    1'b1 |=> pin_oe_o.d == ($past(dir_d_ff) | $past(array_oe_i.d));
  endproperty
  a_oe_or: assert property (p_oe_or) else $error("port D enable wrong");

  // Port B enable is direction OR product term as well
  property p_oe_b;
    1'b1 |=> pin_oe_o.b == ($past(dir_b_ff) | $past(array_oe_i.b));
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("port B enable wrong");

  // Peripheral buffer released when neither select is active
  property p_periph_tri;
    periph_on && !periph_sel |=> pin_oe_o.a == 8'h00;
  endproperty
  a_periph_tri: assert property (p_periph_tri) else $error("peripheral buffer driving");

  // Data port carries host data onto port A
  property p_data_port;
    DATA_PORT_A && data_drive_i |=> pin_oe_o.a == 8'hFF && pin_out_o.a == $past(host_data_i);
  endproperty
  a_data_port: assert property (p_data_port) else $error("data port not driven");

  // Control bit 1 on a mapped pin puts latched address out
  property p_addr_out;
    ctrl_b_ff[0] && amap_b[8] |=> pin_out_o.b[0] == $past(amap_b[0]);
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address bit not on pin");

  // Control bit 0 on a plain pin drives data-out
  property p_mcu_out;
    !ctrl_b_ff[1] && !ARRAY_OUT_MASK.b[1] |=> pin_out_o.b[1] == $past(dout_b_ff[1]);
  endproperty
  a_mcu_out: assert property (p_mcu_out) else $error("data-out not on pin");

  // Address inputs caught on the strobe and held after
  property p_latch;
    address_strobe_i ##1 !address_strobe_i |->
      input_latch_cell_o == ($past(pin_in_i) & ADDR_IN_MASK);
  endproperty
  a_latch: assert property (p_latch) else $error("address input not latched");

  // Either run-time scan enable method turns the scan pins on
  property p_scan;
    scan_enable_i || scan_port_select_i |=> scan_active_o && (pin_oe_o.c & SCAN_PIN_MASK) ==
      (SCAN_PIN_MASK & SCAN_TDO_MASK);
  endproperty
  a_scan: assert property (p_scan) else $error("scan pins not enabled");

endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Host processor seen from the port block: a classic bus master
module host_model
  import port_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  output wb_req_s req_o
);
  initial req_o = '0;

  // One cycle, held until ack is sampled, then released for an idle cycle
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] d,
                      output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b1, we, adr, 4'hF, {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    ok = (ack_i === 1'b1);
    req_o <= '0;
    @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "port_mode_defs.svh"

module tb;
  import port_mode_pkg::*;
  logic clk_i, rst_i, ack, strobe, drive, psa, psb, ssel, sen, tdo, sact, ok;
  logic [31:0] rdat;
  logic [15:0] addr;
  logic [7:0] hdi, hdo, r, d;
  logic [7:0] offs[11];
  wb_req_s req;
  port_pins_s pin_in, pin_out, pin_oe, aout, aoe, ain, ilc, p;
  port_pins_s pin_out2, pin_oe2;
  logic [31:0] exp_q[$];
  int fail_count, num_checks;

  // Array drives port D only; every pin may be latched as address input
  port_mode_select #(.PERIPH_DEFINED(1'b1), .ARRAY_OUT_MASK(27'h7), .ADDR_IN_MASK('1))
  i_port_mode_select (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_ack_o(ack),
    .wb_dat_o(rdat), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .array_out_i(aout), .array_oe_i(aoe), .array_in_o(ain), .input_latch_cell_o(ilc),
    .addr_i(addr), .address_strobe_i(strobe), .host_data_i(hdi), .data_drive_i(drive),
    .host_data_o(hdo), .periph_select_a_i(psa), .periph_select_b_i(psb),
    .scan_port_select_i(ssel), .scan_enable_i(sen), .scan_tdo_i(tdo),
    .scan_active_o(sact));

  // Non-multiplexed host with port A as its data port, on the same bus and pins
  port_mode_select #(.HOST_BUS(BUS_NONMUX8), .DATA_PORT_A(1'b1))
  i_port_mode_select_np (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_ack_o(),
    .wb_dat_o(), .pin_in_i(pin_in), .pin_out_o(pin_out2), .pin_oe_o(pin_oe2),
    .array_out_i(aout), .array_oe_i(aoe), .array_in_o(), .input_latch_cell_o(),
    .addr_i(addr), .address_strobe_i(strobe), .host_data_i(hdi), .data_drive_i(drive),
    .host_data_o(), .periph_select_a_i(psa), .periph_select_b_i(psb),
    .scan_port_select_i(ssel), .scan_enable_i(sen), .scan_tdo_i(tdo),
    .scan_active_o());

  host_model i_host_model (.clk_i(clk_i), .ack_i(ack), .req_o(req));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pcmp(input logic [7:0] got, input logic [7:0] exp);
    cmp({24'h0, got}, {24'h0, exp});
  endtask

  // Reads note their expected byte; a hung cycle ends the run
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] v);
    if (!we) exp_q.push_back({24'h0, v});
    i_host_model.xfer(we, a, v, ok);
    if (!ok) begin
      fail_count++;
      results();
    end
  endtask

  // Pins answer one edge after their cause; sample once it has landed
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // Read data is judged at the edge where the master samples ack
  always @(posedge clk_i) begin
    if (ack === 1'b1 && req.cyc && !req.we) cmp(rdat, exp_q.pop_front());
  end

  initial begin
    rst_i = 1'b1;
    {pin_in, aout, aoe, addr, hdi} = '0;
    {strobe, drive, psa, psb, ssel, sen, tdo} = '0;
    fail_count = 0;
    num_checks = 0;
    offs = '{`OFF_CTRL_A, `OFF_CTRL_B, `OFF_DIR_A, `OFF_DIR_B, `OFF_DIR_C, `OFF_DIR_D,
      `OFF_DOUT_A, `OFF_DOUT_B, `OFF_DOUT_C, `OFF_DOUT_D, `OFF_MEM_MAP};
    void'($urandom(32'h64b017c7));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (offs[i]) bus(1'b0, offs[i], 8'h00);
    // Unmapped place swallows writes and reads zero
    bus(1'b1, 8'hFC, 8'h5A);
    bus(1'b0, 8'hFC, 8'h00);
    // Processor I/O on port B, bit by bit
    r = 8'($urandom);
    d = 8'($urandom);
    bus(1'b1, `OFF_DIR_B, r);
    bus(1'b1, `OFF_DOUT_B, d);
    bus(1'b0, `OFF_DIR_B, r);
    bus(1'b0, `OFF_DOUT_B, d);
    @(posedge clk_i);
    pin_in <= 27'($urandom);
    settle();
    pcmp(pin_oe.b, r);
    pcmp(pin_out.b & r, d & r);
    bus(1'b0, `OFF_DIN_B, pin_in.b);
    bus(1'b0, `OFF_OE_B, r);
    // Direction ORed with product-term enable; port D dir left 0 (array pins) for the checks, then written FF, reads 07
    bus(1'b1, `OFF_DIR_C, r);
    @(posedge clk_i);
    aoe <= 27'($urandom);
    aout <= 27'($urandom);
    settle();
    pcmp(pin_oe.c, r | aoe.c);
    pcmp({5'h0, pin_oe.d}, {5'h0, aoe.d});
    pcmp({5'h0, pin_out.d & aoe.d}, {5'h0, aout.d & aoe.d});
    cmp(32'(ain), 32'(pin_in));
    bus(1'b1, `OFF_DIR_D, 8'hFF);
    bus(1'b0, `OFF_DIR_D, 8'h07);
    // Address out needs both control and direction, set at run time
    @(posedge clk_i);
    aoe <= '0;
    addr <= 16'($urandom);
    bus(1'b1, `OFF_CTRL_A, 8'hFF);
    bus(1'b1, `OFF_DIR_A, 8'hFF);
    bus(1'b1, `OFF_CTRL_B, 8'h0F);
    bus(1'b1, `OFF_DIR_B, 8'h00);
    settle();
    pcmp(pin_out.a, addr[7:0]);
    pcmp(pin_oe.a, 8'hFF);
    pcmp(pin_oe2.a, 8'h00);
    pcmp(pin_oe.b, 8'h00);
    bus(1'b1, `OFF_DIR_B, 8'hFF);
    settle();
    pcmp(pin_out.b, {d[7:4], addr[3:0]});
    pcmp(pin_out2.b, {d[7:4], addr[3:0]});
    // Peripheral buffer follows the two selects while drive stays high
    bus(1'b1, `OFF_MEM_MAP, 8'h80);
    bus(1'b0, `OFF_MEM_MAP, 8'h80);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {psb, psa} <= 2'(i);
      drive <= 1'b1;
      hdi <= 8'($urandom);
      settle();
      pcmp(pin_oe.a, (i != 0) ? 8'hFF : 8'h00);
      if (i != 0) pcmp(pin_out.a, hdi);
      pcmp(hdo, pin_in.a);
      pcmp(pin_oe2.a, 8'hFF);
      pcmp(pin_out2.a, hdi);
    end
    bus(1'b1, `OFF_MEM_MAP, 8'h00);
    settle();
    pcmp(pin_out.a, addr[7:0]);
    // Either scan enable switches the scan pins of port C on
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_i);
      {sen, ssel} <= 2'(j);
      tdo <= 1'($urandom);
      settle();
      cmp({31'h0, sact}, {31'h0, j != 0});
      if (j != 0) pcmp(pin_oe.c & 8'h0F, 8'h08);
      if (j != 0) pcmp({7'h0, pin_out.c[3]}, {7'h0, tdo});
    end
    // Address inputs latch while the strobe is high, then hold
    @(posedge clk_i);
    strobe <= 1'b1;
    settle();
    p = pin_in;
    cmp(32'(ilc), 32'(p));
    @(posedge clk_i);
    strobe <= 1'b0;
    pin_in <= ~p;
    settle();
    cmp(32'(ilc), 32'(p));
    results();
  end
endmodule

`default_nettype wire
